/* inc/sre_regs.svh */
/*
 * Offsets, opcodes, field positions and timing counts of the security
 * register erase/program link. Assumes a 20 MHz reference clock on both ends.
 */
`ifndef SRE_REGS_SVH
`define SRE_REGS_SVH

// -----------------------------------------------------------------
// Opcodes
// -----------------------------------------------------------------
`define SRE_OP_WREN   8'h06
`define SRE_OP_WRDI   8'h04
`define SRE_OP_RDSR1  8'h05
`define SRE_OP_RDSR2  8'h35
`define SRE_OP_ERASE  8'h44
`define SRE_OP_PROG   8'h42

// -----------------------------------------------------------------
// Status bit positions
// -----------------------------------------------------------------
`define SRE_SR1_BUSY  0
`define SRE_SR1_WEL   1
`define SRE_SR2_LB    3

// -----------------------------------------------------------------
// Host register offsets and fields
// -----------------------------------------------------------------
`define SRE_REG_CTRL  8'h00
`define SRE_REG_ADDR  8'h04
`define SRE_REG_DATA  8'h08
`define SRE_REG_STAT  8'h0c
`define SRE_CTRL_LEN_LSB  8
`define SRE_CTRL_HASADDR  17
`define SRE_CTRL_READ     18

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define SRE_CLK_NS        50
`define SRE_T_ERASE_NS    100000
`define SRE_T_PROG_NS     20000
`define SRE_ERASE_CYC     ((`SRE_T_ERASE_NS + `SRE_CLK_NS - 1) / `SRE_CLK_NS)
`define SRE_PROG_CYC      ((`SRE_T_PROG_NS + `SRE_CLK_NS - 1) / `SRE_CLK_NS)
`define SRE_CS_GAP        16

`endif

/* inc/sre_pkg.sv */
/*
 * Types shared by both ends of the security register link.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package sre_pkg;
	typedef enum logic [1:0] {SRE_IDLE, SRE_ERASE, SRE_PROG} sre_dev_e;
	typedef enum logic [2:0] {SRH_IDLE, SRH_SEL, SRH_BIT, SRH_WAIT, SRH_END, SRH_GAP} sre_host_e;
	typedef logic [7:0] sre_byte_t;
endpackage : sre_pkg

`default_nettype wire

/* inc/sre_if.sv */
/*
 * Serial link between host controller and flash command logic.
 * Assumes SPI mode 0: clock idles low, data sampled on rising edges.
 */
`default_nettype none

interface sre_if;
	logic cs_n;
	logic sck;
	logic mosi;
	logic miso;

	modport dev  (input cs_n, input sck, input mosi, output miso);
	modport host (output cs_n, output sck, output mosi, input miso);
endinterface : sre_if

`default_nettype wire

/* src/sre_flash.sv */
/*
 * Flash-side command logic for erasing and programming three 256-byte
 * security registers. Bits are taken on the link clock; execution runs on
 * REF_CLK after chip select rises. Assumes the host keeps chip select high
 * for at least 16 REF_CLK cycles between frames.
 */
`default_nettype none
`include "sre_regs.svh"

module sre_flash (
	sre_if.dev                LINK,
	input  wire logic         REF_CLK,
	input  wire logic         RST_N,
	input  wire logic         CE,
	input  wire logic         QPI_MODE,
	input  wire logic [2:0]   LOCK,
	input  wire logic [9:0]   RD_ADDR,
	output logic      [7:0]   RD_DATA,
	output logic              BUSY,
	output logic              WRITE_ENABLE_LATCH
);

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	function automatic logic addr_ok(input logic [23:0] a);
		addr_ok = (a[23:16] == 8'h00) && (a[11:8] == 4'h0) &&
			(a[15:12] >= 4'h1) && (a[15:12] <= 4'h3);
	endfunction : addr_ok

	function automatic logic [9:0] mem_idx(input logic [1:0] b, input logic [7:0] o);
		mem_idx = {b, o};
	endfunction : mem_idx

	// -----------------------------------------------------------------
	// Link clock domain
	// -----------------------------------------------------------------
	logic                started;
	logic [2:0]          bitc;
	logic [2:0]          bytec;
	logic [7:0]          shift;
	logic [7:0]          opcode;
	logic [23:0]         addr;
	logic [7:0]          ptr;
	logic [7:0]          pbuf [0:255];
	logic [255:0]        pmask;
	logic [7:0]          osr;
	logic [4:0]          st1;
	logic [4:0]          st2;
	logic                frame_rst;
	logic [2:0]          bc;
	logic [2:0]          byc;
	logic [7:0]          nsh;
	logic [7:0]          nop;
	logic                pb_wr;
	logic [2:0]          lk1;
	logic [2:0]          lk;

	assign frame_rst = ~RST_N | LINK.cs_n;
	assign bc        = started ? bitc : 3'h0;
	assign byc       = started ? bytec : 3'h0;
	assign nsh       = {shift[6:0], LINK.mosi};
	assign nop       = (byc == 3'h0) ? nsh : opcode;
	assign pb_wr     = started && (bc == 3'h7) && (byc >= 3'h4) &&
		(opcode == `SRE_OP_PROG) && !st2[0];

	// Frame start marker, cleared while chip select is high
	always_ff @(posedge LINK.sck or posedge frame_rst) begin
		if (frame_rst) begin
			started <= 1'b0;
		end else begin
			started <= 1'b1;
		end
	end

	// Bit and byte capture; counters hold after the frame for REF_CLK
	always_ff @(posedge LINK.sck or negedge RST_N) begin
		if (!RST_N) begin
			bitc   <= 3'h0;
			bytec  <= 3'h0;
			shift  <= 8'h00;
			opcode <= 8'h00;
			addr   <= 24'h000000;
			ptr    <= 8'h00;
		end else begin
			bitc  <= 3'(bc + 3'h1);
			shift <= nsh;
			if (bc == 3'h7) begin
				if (byc < 3'h5) begin
					bytec <= 3'(byc + 3'h1);
				end
				case (byc)
					3'h0: opcode <= nsh;
					3'h1: addr[23:16] <= nsh;
					3'h2: addr[15:8] <= nsh;
					3'h3: begin
						addr[7:0] <= nsh;
						ptr       <= nsh;
					end
					default: if (pb_wr) begin
						ptr <= 8'(ptr + 8'h01);
					end
				endcase
			end else if (!started) begin
				bytec <= 3'h0;
			end
		end
	end

	// Byte mask of the page buffer, cleared on each new program opcode taken while not busy
	always_ff @(posedge LINK.sck or negedge RST_N) begin
		if (!RST_N) begin
			pmask <= '0;
		end else if (bc == 3'h7 && byc == 3'h0 && nsh == `SRE_OP_PROG && !st2[0]) begin
			pmask <= '0;
		end else if (pb_wr) begin
			pmask[ptr] <= 1'b1;
		end
	end

	always_ff @(posedge LINK.sck) begin
		if (pb_wr) begin
			pbuf[ptr] <= nsh;
		end
	end

	// Busy, write enable and lock bits brought into the link domain
	always_ff @(posedge LINK.sck or negedge RST_N) begin
		if (!RST_N) begin
			st1 <= 5'h00;
			st2 <= 5'h00;
		end else begin
			st1 <= {lk, WRITE_ENABLE_LATCH, BUSY};
			st2 <= st1;
		end
	end

	// Status byte shifted out, reloaded at every byte boundary
	always_ff @(posedge LINK.sck or negedge RST_N) begin
		if (!RST_N) begin
			osr <= 8'h00;
		end else if (bc == 3'h7) begin
			if (nop == `SRE_OP_RDSR1) begin
				osr <= {6'h00, st2[1], st2[0]};
			end else if (nop == `SRE_OP_RDSR2) begin
				osr <= {2'h0, st2[4:2], 3'h0};
			end else begin
				osr <= 8'h00;
			end
		end else begin
			osr <= {osr[6:0], 1'b0};
		end
	end

	always_ff @(negedge LINK.sck or negedge RST_N) begin
		if (!RST_N) begin
			LINK.miso <= 1'b0;
		end else begin
			LINK.miso <= osr[7];
		end
	end

	// -----------------------------------------------------------------
	// Reference clock domain
	// -----------------------------------------------------------------
	sre_pkg::sre_dev_e   state;
	logic [2:0]          cs_s;
	logic [1:0]          qpi_s;
	logic [15:0]         timer;
	logic [1:0]          base;
	logic [7:0]          mem [0:767];
	logic                cs_rise;
	logic [1:0]          sel;
	logic                cmd_ok;

	assign cs_rise = cs_s[1] & ~cs_s[2];
	assign sel     = 2'(addr[13:12] - 2'h1);
	// Link registers are quiet here: sck is stopped while chip select is high
	assign cmd_ok  = WRITE_ENABLE_LATCH && (bitc == 3'h0) && addr_ok(addr) && !lk[sel] &&
		((opcode == `SRE_OP_ERASE) ? (bytec == 3'h4) : (bytec == 3'h5));

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cs_s  <= 3'h7;
			qpi_s <= 2'h0;
			lk1   <= 3'h0;
			lk    <= 3'h0;
		end else if (CE) begin
			cs_s  <= {cs_s[1:0], LINK.cs_n};
			qpi_s <= {qpi_s[0], QPI_MODE};
			lk1   <= LOCK;
			lk    <= lk1;
		end
	end

	// Command execution and self-timed cycles
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= sre_pkg::SRE_IDLE;
			BUSY  <= 1'b0;
			WRITE_ENABLE_LATCH   <= 1'b0;
			timer <= 16'h0000;
			base  <= 2'h0;
		end else if (CE) begin
			case (state)
				sre_pkg::SRE_IDLE: begin
					if (cs_rise && !qpi_s[1]) begin
						case (opcode)
							`SRE_OP_WREN: WRITE_ENABLE_LATCH <= 1'b1;
							`SRE_OP_WRDI: WRITE_ENABLE_LATCH <= 1'b0;
							`SRE_OP_ERASE, `SRE_OP_PROG: begin
								if (cmd_ok) begin
									state <= (opcode == `SRE_OP_ERASE) ?
										sre_pkg::SRE_ERASE : sre_pkg::SRE_PROG;
									BUSY  <= 1'b1;
									timer <= 16'h0000;
									base  <= sel;
								end
							end
							default: ;
						endcase
					end
				end
				sre_pkg::SRE_ERASE: begin
					timer <= 16'(timer + 16'h0001);
					if (timer == 16'(`SRE_ERASE_CYC - 1)) begin
						state <= sre_pkg::SRE_IDLE;
						BUSY  <= 1'b0;
						WRITE_ENABLE_LATCH   <= 1'b0;
					end
				end
				sre_pkg::SRE_PROG: begin
					timer <= 16'(timer + 16'h0001);
					if (timer == 16'(`SRE_PROG_CYC - 1)) begin
						state <= sre_pkg::SRE_IDLE;
						BUSY  <= 1'b0;
						WRITE_ENABLE_LATCH   <= 1'b0;
					end
				end
				default: state <= sre_pkg::SRE_IDLE;
			endcase
		end
	end

	// Array updates in the first 256 cycles of a cycle; program only clears bits, erase sets every byte to ff
	always_ff @(posedge REF_CLK) begin
		if (CE && timer < 16'h0100) begin
			if (state == sre_pkg::SRE_ERASE) begin
				mem[mem_idx(base, timer[7:0])] <= 8'hff;
			end else if (state == sre_pkg::SRE_PROG && pmask[timer[7:0]]) begin
				mem[mem_idx(base, timer[7:0])] <=
					mem[mem_idx(base, timer[7:0])] & pbuf[timer[7:0]];
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			RD_DATA <= 8'h00;
		end else if (CE) begin
			RD_DATA <= (RD_ADDR < 10'd768) ? mem[RD_ADDR] : 8'hff;
		end
	end

endmodule : sre_flash

`default_nettype wire

/* src/sre_host.sv */
/*
 * Host controller for the security register link, driven over APB.
 * Derives the serial clock from REF_CLK by eight. Assumes a flash on the
 * far side that samples on rising and drives on falling serial clock.
 */
`default_nettype none
`include "sre_regs.svh"

module sre_host (
	sre_if.host               LINK,
	input  wire logic         REF_CLK,
	input  wire logic         RST_N,
	input  wire logic         CE,
	input  wire logic         PSEL,
	input  wire logic         PENABLE,
	input  wire logic         PWRITE,
	input  wire logic [7:0]   PADDR,
	input  wire logic [31:0]  PWDATA,
	output logic      [31:0]  PRDATA,
	output logic              PREADY,
	output logic              PSLVERR
);

	sre_pkg::sre_host_e  state;
	logic [7:0]          op;
	logic [23:0]         addr;
	logic [8:0]          left;
	logic                has_addr;
	logic                rd;
	logic [7:0]          data;
	logic                data_full;
	logic [7:0]          rdata;
	logic [7:0]          tx;
	logic [7:0]          rx;
	logic [2:0]          ph;
	logic [2:0]          bitn;
	logic [1:0]          idx;
	logic [4:0]          gap;
	logic [1:0]          miso_s;
	logic                wr_acc;
	logic                take;
	logic                known;

	assign wr_acc = PSEL & PENABLE & PREADY & PWRITE;
	assign known  = (PADDR == `SRE_REG_CTRL) || (PADDR == `SRE_REG_ADDR) ||
		(PADDR == `SRE_REG_DATA) || (PADDR == `SRE_REG_STAT);
	// Byte is consumed only where the engine loads it
	assign take   = (state == sre_pkg::SRH_WAIT);

	// -----------------------------------------------------------------
	// APB slave, one wait-free access phase
	// -----------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h00000000;
		end else if (CE) begin
			PREADY  <= PSEL & ~PENABLE & ~PREADY;
			PSLVERR <= PSEL & ~PENABLE & ~known;
			PRDATA  <= 32'h00000000;
			if (PSEL && !PENABLE && !PWRITE) begin
				case (PADDR)
					`SRE_REG_ADDR: PRDATA <= {8'h00, addr};
					`SRE_REG_STAT: PRDATA <= {16'h0000, rdata, 6'h00, data_full,
						state != sre_pkg::SRH_IDLE};
					default: PRDATA <= 32'h00000000;
				endcase
			end
		end
	end

	// Write data byte; a new write wins over the engine's take
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			data      <= 8'h00;
			data_full <= 1'b0;
		end else if (CE) begin
			if (wr_acc && PADDR == `SRE_REG_DATA) begin
				data      <= PWDATA[7:0];
				data_full <= 1'b1;
			end else if (take && !rd && left != 9'h000 &&
				!(has_addr && idx != 2'h3) && data_full) begin
				data_full <= 1'b0;
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			miso_s <= 2'h0;
		end else if (CE) begin
			miso_s <= {miso_s[0], LINK.miso};
		end
	end

	// -----------------------------------------------------------------
	// Serial engine
	// -----------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state     <= sre_pkg::SRH_IDLE;
			op        <= 8'h00;
			addr      <= 24'h000000;
			left      <= 9'h000;
			has_addr  <= 1'b0;
			rd        <= 1'b0;
			rdata     <= 8'h00;
			tx        <= 8'h00;
			rx        <= 8'h00;
			ph        <= 3'h0;
			bitn      <= 3'h0;
			idx       <= 2'h0;
			gap       <= 5'h00;
			LINK.cs_n <= 1'b1;
			LINK.sck  <= 1'b0;
			LINK.mosi <= 1'b0;
		end else if (CE) begin
			if (wr_acc && PADDR == `SRE_REG_ADDR) begin
				addr <= PWDATA[23:0];
			end
			case (state)
				sre_pkg::SRH_IDLE: begin
					if (wr_acc && PADDR == `SRE_REG_CTRL) begin
						op        <= PWDATA[7:0];
						tx        <= PWDATA[7:0];
						left      <= PWDATA[`SRE_CTRL_LEN_LSB +: 9];
						has_addr  <= PWDATA[`SRE_CTRL_HASADDR];
						rd        <= PWDATA[`SRE_CTRL_READ];
						idx       <= 2'h0;
						LINK.cs_n <= 1'b0;
						state     <= sre_pkg::SRH_SEL;
					end
				end
				sre_pkg::SRH_SEL: begin
					ph    <= 3'h0;
					bitn  <= 3'h0;
					state <= sre_pkg::SRH_BIT;
				end
				sre_pkg::SRH_BIT: begin
					ph <= 3'(ph + 3'h1);
					case (ph)
						3'h0: LINK.mosi <= tx[7];
						3'h2: LINK.sck <= 1'b1;
						3'h5: rx <= {rx[6:0], miso_s[1]};
						3'h6: LINK.sck <= 1'b0;
						3'h7: begin
							tx   <= {tx[6:0], 1'b0};
							bitn <= 3'(bitn + 3'h1);
							if (bitn == 3'h7) begin
								if (rd && idx == 2'h3) begin
									rdata <= rx;
								end
								state <= sre_pkg::SRH_WAIT;
							end
						end
						default: ;
					endcase
				end
				sre_pkg::SRH_WAIT: begin
					ph <= 3'h0;
					if (has_addr && idx != 2'h3) begin
						idx   <= 2'(idx + 2'h1);
						tx    <= addr[8'(5'd23 - {idx, 3'h0}) -: 8];
						state <= sre_pkg::SRH_BIT;
					end else if (left != 9'h000) begin
						idx <= 2'h3;
						if (rd || data_full) begin
							tx    <= rd ? 8'h00 : data;
							left  <= 9'(left - 9'h001);
							state <= sre_pkg::SRH_BIT;
						end
					end else begin
						state <= sre_pkg::SRH_END;
					end
				end
				sre_pkg::SRH_END: begin
					LINK.cs_n <= 1'b1;
					gap       <= 5'h00;
					state     <= sre_pkg::SRH_GAP;
				end
				sre_pkg::SRH_GAP: begin
					gap <= 5'(gap + 5'h01);
					if (gap == 5'(`SRE_CS_GAP - 1)) begin
						state <= sre_pkg::SRH_IDLE;
					end
				end
				default: state <= sre_pkg::SRH_IDLE;
			endcase
		end
	end

endmodule : sre_host

`default_nettype wire

/* tb/sre_monitor.sv */
/*
 * Checker on the serial link between sre_host and sre_flash.
 * Assumes sck is made from REF_CLK and so is sampled on it.
 */
`default_nettype none

module sre_monitor (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic BUSY,
	input wire logic WRITE_ENABLE_LATCH
);
	logic        sck_q;
	logic [2:0]  bits;
	logic [11:0] busy_cnt;

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);

	// -----------------------------------------------------------------
	// Bit and busy counters
	// -----------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sck_q <= 1'b0;
			bits <= 3'h0;
			busy_cnt <= 12'h000;
		end else begin
			sck_q <= sck;
			bits <= cs_n ? 3'h0 : bits + 3'(sck && !sck_q);
			busy_cnt <= BUSY ? busy_cnt + 12'h001 : 12'h000;
		end
	end

	sequence s_gap;
		cs_n [*8] ##1 cs_n [*8];
	endsequence

	// -----------------------------------------------------------------
	// Properties
	// -----------------------------------------------------------------
	a_sck_idle_low: assert property (cs_n |-> !sck)
		else $error("sck moves while deselected");
	a_mosi_held: assert property ($rose(sck) |-> $stable(mosi))
		else $error("mosi changes at sck rise");
	a_sck_pulse: assert property ($rose(sck) |-> sck [*3] ##[1:2] !sck)
		else $error("sck high phase wrong");
	a_byte_frame: assert property ($rose(cs_n) |-> bits == 3'h0)
		else $error("frame not whole bytes");
	a_cs_gap: assert property ($rose(cs_n) |-> s_gap)
		else $error("chip select gap too short");
	a_busy_cause: assert property ($rose(BUSY) |-> cs_n && WRITE_ENABLE_LATCH)
		else $error("busy without latch or in frame");
	a_busy_span: assert property ($fell(BUSY) |-> busy_cnt inside
		{[12'd398:12'd402], [12'd1998:12'd2002]})
		else $error("busy length wrong");
	a_wel_cleared: assert property ($fell(BUSY) |-> !WRITE_ENABLE_LATCH)
		else $error("latch not cleared at end");
endmodule : sre_monitor

`default_nettype wire

/* tb/security_register_erase_program_test.sv */
/*
 * Self-checking bench: sre_host over APB drives sre_flash through sre_if.
 * Assumes a 20 MHz REF_CLK and the host register map of the hand-over.
 */
`default_nettype none

module security_register_erase_program_test;
	timeunit 1ns;
	timeprecision 1ns;

	logic        REF_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic        QPI_MODE, BUSY, WRITE_ENABLE_LATCH, last_err;
	logic [7:0]  PADDR, RD_DATA;
	logic [31:0] PWDATA, PRDATA;
	logic [2:0]  LOCK;
	logic [9:0]  RD_ADDR;
	logic [7:0]  mem [3][256];
	bit          known [3];
	int          failures, samples_checked;

	sre_if link ();
	sre_host i_sre_host (.LINK(link), .REF_CLK(REF_CLK), .RST_N(RST_N), .CE(1'b1),
		.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
	sre_flash i_sre_flash (.LINK(link), .REF_CLK(REF_CLK), .RST_N(RST_N), .CE(1'b1),
		.QPI_MODE(QPI_MODE), .LOCK(LOCK), .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA),
		.BUSY(BUSY), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH));
	sre_monitor i_sre_monitor (.REF_CLK(REF_CLK), .RST_N(RST_N), .cs_n(link.cs_n),
		.sck(link.sck), .mosi(link.mosi), .BUSY(BUSY), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH));

	initial begin
		REF_CLK = 1'b0;
		forever #25 REF_CLK = ~REF_CLK;
	end

	// -----------------------------------------------------------------
	// Bus and check tasks
	// -----------------------------------------------------------------
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task end_sim;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge REF_CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		do @(posedge REF_CLK); while (PREADY !== 1'b1);
		r = PRDATA;
		last_err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb

	task go(input logic [31:0] c, input logic [7:0] b, input bit more);
		logic [31:0] r;
		apb(1'b1, 8'h00, c, r);
		apb(1'b0, 8'h0c, 32'h0, r);
		while (r[0] === 1'b1) begin
			if (more && r[1] === 1'b0) begin
				apb(1'b1, 8'h08, {24'h0, b}, r);
				more = 1'b0;
			end
			apb(1'b0, 8'h0c, 32'h0, r);
		end
		repeat (20) @(posedge REF_CLK);
	endtask : go

	task sr(input logic [7:0] o, output logic [7:0] s);
		logic [31:0] r;
		go({24'h000401, o}, 8'h00, 1'b0);
		apb(1'b0, 8'h0c, 32'h0, r);
		s = r[15:8];
	endtask : sr

	function bit hit(input logic [23:0] a, input logic [2:0] lk);
		return a[23:16] == 8'h00 && a[11:8] == 4'h0 && a[15:12] inside {4'h1, 4'h2, 4'h3}
			&& !lk[a[13:12] - 2'h1];
	endfunction : hit

	// Kind 0 erase, 1 two-byte program, 2 erase with a stray byte
	task op(input int kind, input logic [23:0] a, input bit wr, input logic [2:0] lk,
		input bit qpi);
		logic [31:0] r;
		logic [7:0]  d0, d1, s;
		int          n, ix;
		bit          h, seen, we;
		d0 = 8'($urandom);
		d1 = 8'($urandom);
		ix = int'(a[13:12]) - 1;
		we = wr && !qpi;
		h = we && kind != 2 && hit(a, lk);
		LOCK <= lk;
		go(32'h00000004, 8'h00, 1'b0);
		QPI_MODE <= qpi;
		if (wr) go(32'h00000006, 8'h00, 1'b0);
		chk("wel_set", 32'(we), 32'(WRITE_ENABLE_LATCH));
		apb(1'b1, 8'h04, {8'h0, a}, r);
		apb(1'b0, 8'h04, 32'h0, r);
		chk("addr_reg", {8'h0, a}, r);
		if (kind != 0) apb(1'b1, 8'h08, {24'h0, d0}, r);
		go(kind == 0 ? 32'h00020044 : kind == 1 ? 32'h00020242 : 32'h00020144, d1, kind == 1);
		seen = 1'b0;
		repeat (20) begin
			@(posedge REF_CLK);
			seen |= (BUSY === 1'b1);
		end
		QPI_MODE <= 1'b0;
		chk("busy_start", 32'(h), 32'(seen));
		if (h) begin
			sr(8'h05, s);
			chk("status_busy", 32'h3, 32'(s[1:0]));
		end
		n = 0;
		while (BUSY !== 1'b0 && n < 3000) begin
			@(posedge REF_CLK);
			n++;
		end
		sr(8'h05, s);
		chk("status_idle", 32'({we && !h, 1'b0}), 32'(s[1:0]));
		sr(8'h35, s);
		chk("lock_bits", 32'(lk), 32'(s[5:3]));
		if (h && kind == 0) begin
			for (n = 0; n < 256; n++) mem[ix][n] = 8'hff;
			known[ix] = 1'b1;
		end
		if (h && kind == 1) begin
			mem[ix][a[7:0]] &= d0;
			mem[ix][a[7:0] + 8'h1] &= d1;
		end
		if (ix >= 0 && known[ix]) begin
			for (n = 0; n < 256; n++) begin
				RD_ADDR <= {2'(ix), 8'(n)};
				repeat (2) @(posedge REF_CLK);
				chk("sec_data", 32'(mem[ix][n]), 32'(RD_DATA));
			end
		end
		$display("op kind %0d addr %h done", kind, a);
	endtask : op

	// -----------------------------------------------------------------
	// Main sequence and watchdog
	// -----------------------------------------------------------------
	initial begin
		logic [31:0] r;
		{PSEL, PENABLE, PWRITE, QPI_MODE, RST_N} = 5'h0;
		PADDR = 8'h00;
		PWDATA = 32'h0;
		LOCK = 3'h0;
		RD_ADDR = 10'h000;
		failures = 0;
		samples_checked = 0;
		void'($urandom(32'h001f));
		repeat (6) @(posedge REF_CLK);
		RST_N <= 1'b1;
		apb(1'b0, 8'h10, 32'h0, r);
		chk("unmapped_err", 32'h1, 32'(last_err));
		op(0, 24'h0010a5, 1'b1, 3'h0, 1'b0);
		op(1, 24'h0010ff, 1'b1, 3'h0, 1'b0);
		op(0, 24'h002000, 1'b0, 3'h0, 1'b0);
		op(0, 24'h003011, 1'b1, 3'h4, 1'b0);
		op(0, 24'h0020ee, 1'b1, 3'h0, 1'b0);
		op(1, 24'h001010, 1'b1, 3'h1, 1'b0);
		op(2, 24'h001000, 1'b1, 3'h0, 1'b0);
		op(0, 24'h001000, 1'b1, 3'h0, 1'b1);
		op(0, 24'h001100, 1'b1, 3'h0, 1'b0);
		op(1, 24'h012000, 1'b1, 3'h0, 1'b0);
		op(1, 24'h002040, 1'b0, 3'h0, 1'b0);
		op(1, 24'h002040, 1'b1, 3'h0, 1'b0);
		for (int i = 0; i < 5; i++) begin
			op(int'($urandom_range(1, 0)), {8'h0, 4'($urandom_range(3, 1)), 4'h0, 8'($urandom)},
				1'b1, ($urandom_range(3, 0) == 0) ? 3'($urandom) : 3'h0, 1'b0);
		end
		end_sim();
	end

	initial begin
		repeat (90000) @(posedge REF_CLK);
		failures++;
		end_sim();
	end
endmodule : security_register_erase_program_test

`default_nettype wire
